// >>> core/pdss_core.sv
// Pipelined double-cycle-deselect synchronous SRAM core
`timescale 1ns/1ps
module pdss_core
   import pdss_pkg::*;
(
   input  wire logic                   mclk_i,
   input  wire logic                   sys_rst_i,
   input  wire logic [ADDR_W-1:0]      addr_i,
   input  wire logic                   pipelined_chip_select_n_i,
   input  wire logic                   depth_select_high_i,
   input  wire logic                   depth_select_low_n_i,
   input  wire logic                   processor_addr_strobe_n_i,
   input  wire logic                   controller_addr_strobe_n_i,
   input  wire logic                   burst_advance_n_i,
   input  wire logic [LANES-1:0]       byte_write_select_n_i,
   input  wire logic                   byte_write_enable_n_i,
   input  wire logic                   global_write_n_i,
   input  wire logic                   burst_order_i,
   input  wire logic                   output_enable_n_i,
   input  wire logic                   sleep_input_i,
   input  wire logic [LANES*BYTE_W-1:0] dq_in_i,
   input  wire logic [LANES-1:0]       parity_data_in_i,
   output logic      [LANES*BYTE_W-1:0] dq_out_o,
   output logic      [LANES-1:0]       parity_data_out_o,
   output logic      [LANES-1:0]       dq_oe_o,
   output logic      [LANES-1:0]       parity_data_oe_o
);

   // Input decode
   logic                   chip_en;
   logic                   proc_load;
   logic                   ctrl_load;
   logic                   load;
   logic                   cont;
   logic                   step;
   logic [LANES-1:0]       wr_bytes;
   logic                   write_req;
   logic [DATA_W-1:0]      wdata_in;

   // Burst address state
   logic                   sel_r;
   logic                   sel_nxt;
   logic [ADDR_W-1:0]      base_r;
   logic [ADDR_W-1:0]      base_nxt;
   logic [CTR_W-1:0]       ofs;
   logic [ADDR_W-1:0]      acc_addr;

   // Pipeline registers
   pdss_acc_type           acc_r;
   pdss_acc_type           acc_nxt;
   logic [DATA_W-1:0]      rdata_r;
   logic                   rvld_r;
   logic [DATA_W-1:0]      dout_r;
   logic                   drive_r;
   logic                   drive_ext_r;
   logic [DATA_W-1:0]      lane_rd;
   logic                   out_on;

   // All three chip enables must be active for a selecting load
   assign chip_en   = ~pipelined_chip_select_n_i & depth_select_high_i & ~depth_select_low_n_i;

   // Processor strobe is ignored while the pipelined select is high
   assign proc_load = ~processor_addr_strobe_n_i & ~pipelined_chip_select_n_i;
   assign ctrl_load = ~controller_addr_strobe_n_i & ~proc_load;
   assign load      = proc_load | ctrl_load;
   assign cont      = ~load & sel_r;
   assign step      = cont & ~burst_advance_n_i;

   // Byte write selection; global write overrides the byte controls
   assign wr_bytes  = ~global_write_n_i ? BE_ALL
                    : (~byte_write_enable_n_i ? ~byte_write_select_n_i : BE_RST);
   assign write_req = |wr_bytes;

   // Lane layout: parity bit above each data byte
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_win
         assign wdata_in[g*LANE_W +: LANE_W] = {parity_data_in_i[g], dq_in_i[g*BYTE_W +: BYTE_W]};
      end
   endgenerate

   // Address and select latch only on a strobe edge
   assign sel_nxt  = load ? chip_en : sel_r;
   assign base_nxt = load ? addr_i : base_r;

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sel_r  <= 1'h0;
         base_r <= ADDR_RST;
      end
      else
      begin
         sel_r  <= sel_nxt;
         base_r <= base_nxt;
      end
   end

   // Burst counter seeded from the low address bits
   pdss_burst_ctr u_ctr
   (
      .mclk_i        (mclk_i),
      .sys_rst_i     (sys_rst_i),
      .load_i        (load),
      .start_i       (addr_i[CTR_W-1:0]),
      .step_i        (step),
      .burst_order_i (burst_order_i),
      .ofs_o         (ofs)
   );

   // Upper bits stay fixed for the whole burst, so the group wraps
   assign acc_addr = {base_r[ADDR_W-1:CTR_W], ofs};

   // Processor-strobe loads are always reads; write controls apply on later cycles
   always_comb
   begin
      acc_nxt      = ACC_RST;
      acc_nxt.wr   = ((ctrl_load & chip_en) | cont) & write_req;
      acc_nxt.rd   = ((load & chip_en) | cont) & ~acc_nxt.wr;
      acc_nxt.be   = acc_nxt.wr ? wr_bytes : BE_RST;
      acc_nxt.data = wdata_in;
   end

   // Controls and write data captured together with the address
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         acc_r <= ACC_RST;
      else
         acc_r <= acc_nxt;
   end

   // Array, one memory per lane so each byte writes on its own
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         logic [LANE_W-1:0] lane_mem [DEPTH];

         // Self-timed write: no further controller timing needed
         always_ff @(posedge mclk_i)
         begin
            if (acc_r.wr && acc_r.be[g])
               lane_mem[acc_addr] <= acc_r.data[g*LANE_W +: LANE_W];
         end

         assign lane_rd[g*LANE_W +: LANE_W] = lane_mem[acc_addr];
      end
   endgenerate

   // Array read stage; data is held when no read is pending
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rdata_r <= DATA_RST;
         rvld_r  <= 1'h0;
      end
      else
      begin
         rvld_r <= acc_r.rd;
         if (acc_r.rd)
            rdata_r <= lane_rd;
      end
   end

   // Output register one edge after the array access
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         dout_r  <= DATA_RST;
         drive_r <= 1'h0;
      end
      else
      begin
         drive_r <= rvld_r;
         if (rvld_r)
            dout_r <= rdata_r;
      end
   end

   // Extra enable stage keeps drivers on one more cycle after a deselect,
   // so a second bank must wait out this extra cycle before taking the bus
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         drive_ext_r <= 1'h0;
      else
         drive_ext_r <= drive_r;
   end

   // Output enable and sleep gate the drivers without any clock
   assign out_on = (drive_r | drive_ext_r) & ~output_enable_n_i & ~sleep_input_i;

   // Pin split: byte and parity bits of each lane
   generate
      for (g = 0; g < LANES; g++)
      begin : g_out
         assign dq_out_o[g*BYTE_W +: BYTE_W] = dout_r[g*LANE_W +: BYTE_W];
         assign parity_data_out_o[g]         = dout_r[g*LANE_W + PAR_POS];
         assign dq_oe_o[g]                   = out_on;
         assign parity_data_oe_o[g]          = out_on;
      end
   endgenerate

endmodule : pdss_core

// >>> core/pdss_pkg.sv
// Shared constants and carrier types for the pipelined double-cycle-deselect sync SRAM
package pdss_pkg;

   // Array geometry, wide variant: 1M words of 36 bits
   localparam int ADDR_W   = 20;
   localparam int LANES    = 4;
   localparam int LANE_W   = 9;
   localparam int BYTE_W   = 8;
   localparam int DATA_W   = LANES * LANE_W;
   localparam int DEPTH    = 1 << ADDR_W;
   localparam int CTR_W    = 2;

   // Field positions inside a stored lane: parity bit sits above the byte
   localparam int PAR_POS  = 8;

   // Read latency in clock edges from the address strobe edge to valid data
   localparam int READ_LAT = 3;

   // Burst order select levels
   localparam logic ORDER_LINEAR = 1'h0;
   localparam logic ORDER_INTLV  = 1'h1;

   // Reset values
   localparam logic [CTR_W-1:0]  CTR_RST  = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
   localparam logic [LANES-1:0]  BE_RST   = 4'h0;
   localparam logic [LANES-1:0]  BE_ALL   = 4'hF;

   // One access as it leaves the input registers
   typedef struct packed
   {
      logic              wr;
      logic              rd;
      logic [LANES-1:0]  be;
      logic [DATA_W-1:0] data;
   } pdss_acc_type;

   localparam pdss_acc_type ACC_RST = '{wr: 1'h0, rd: 1'h0, be: BE_RST, data: DATA_RST};

endpackage : pdss_pkg

// >>> core/pdss_burst_ctr.sv
// Two-bit burst counter with linear or interleaved address order
`timescale 1ns/1ps
module pdss_burst_ctr
   import pdss_pkg::*;
(
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             load_i,
   input  wire logic [CTR_W-1:0] start_i,
   input  wire logic             step_i,
   input  wire logic             burst_order_i,
   output logic      [CTR_W-1:0] ofs_o
);

   logic [CTR_W-1:0] start_r;
   logic [CTR_W-1:0] count_r;
   logic [CTR_W-1:0] start_nxt;
   logic [CTR_W-1:0] count_nxt;

   // Load wins over a step; the count wraps inside the four-word group
   assign start_nxt = load_i ? start_i : start_r;
   assign count_nxt = load_i ? CTR_RST
                    : (step_i ? CTR_W'(count_r + 2'h1) : count_r);

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         start_r <= CTR_RST;
         count_r <= CTR_RST;
      end
      else
      begin
         start_r <= start_nxt;
         count_r <= count_nxt;
      end
   end

   // Interleaved order flips start bits, linear order adds modulo four
   assign ofs_o = (burst_order_i == ORDER_INTLV) ? (start_r ^ count_r)
                : CTR_W'(start_r + count_r);

endmodule : pdss_burst_ctr

// >>> tb/pdss_core_chk.sv
// Port-level assertions for the sync SRAM core
`timescale 1ns/1ps
module pdss_core_chk
   import pdss_pkg::*;
(
   input wire logic                    mclk_i,
   input wire logic                    sys_rst_i,
   input wire logic                    pipelined_chip_select_n_i,
   input wire logic                    depth_select_high_i,
   input wire logic                    depth_select_low_n_i,
   input wire logic                    processor_addr_strobe_n_i,
   input wire logic                    controller_addr_strobe_n_i,
   input wire logic [LANES-1:0]        byte_write_select_n_i,
   input wire logic                    byte_write_enable_n_i,
   input wire logic                    global_write_n_i,
   input wire logic                    output_enable_n_i,
   input wire logic                    sleep_input_i,
   input wire logic [LANES*BYTE_W-1:0] dq_out_o,
   input wire logic [LANES-1:0]        dq_oe_o,
   input wire logic [LANES-1:0]        parity_data_oe_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Bus cycle kinds as the core decodes them at an edge
   wire chip_en = ~pipelined_chip_select_n_i & depth_select_high_i & ~depth_select_low_n_i;
   wire wr_req  = ~global_write_n_i | (~byte_write_enable_n_i & ~&byte_write_select_n_i);
   wire rd_ld   = ~controller_addr_strobe_n_i & chip_en & ~wr_req;
   wire desel   = ~controller_addr_strobe_n_i & ~chip_en;
   wire quiet   = controller_addr_strobe_n_i & (processor_addr_strobe_n_i | pipelined_chip_select_n_i);
   wire gated   = output_enable_n_i | sleep_input_i;

   oe_pair_a: assert property (parity_data_oe_o == dq_oe_o) else $error("lane enables differ");
   sleep_off_a: assert property (sleep_input_i |-> dq_oe_o == 4'h0) else $error("driving in sleep");
   oe_gate_a: assert property (output_enable_n_i |-> dq_oe_o == 4'h0) else $error("driving while disabled");
   rd_lat_a: assert property (rd_ld |-> ##3 (gated || dq_oe_o == 4'hF)) else $error("read late");
   dcd_on_a: assert property (rd_ld ##1 desel |-> ##3 (gated || dq_oe_o == 4'hF)) else $error("tail short");
   idle_off_a: assert property (desel ##1 quiet[*4] |-> dq_oe_o == 4'h0) else $error("tail long");
   dout_hold_a: assert property (desel ##1 quiet[*4] |-> $stable(dq_out_o)) else $error("data moved");
   rst_quiet_a: assert property ($fell(sys_rst_i) |-> dq_oe_o == 4'h0) else $error("driving at reset");

   // Main traffic kinds
   read_c: cover property (rd_ld);
   tail_c: cover property (rd_ld ##1 desel);
   write_c: cover property (~controller_addr_strobe_n_i & chip_en & wr_req);
endmodule : pdss_core_chk

bind pdss_core pdss_core_chk pdss_core_chk_i (.*);

// >>> tb/pdss_ctl_model.sv
// Controller-side bus model driving the core's synchronous inputs
`timescale 1ns/1ps
module pdss_ctl_model
   import pdss_pkg::*;
(
   input  wire logic              mclk_i,
   output logic      [4:0]        ctl_o,
   output logic      [5:0]        wctl_o,
   output logic      [ADDR_W-1:0] a_o,
   output logic      [DATA_W-1:0] d_o
);
   // Idle bus: no strobe, no write
   initial
   begin
      ctl_o = 5'h1F;
      wctl_o = 6'h3F;
      a_o = ADDR_RST;
      d_o = DATA_RST;
   end

   // One cycle from the falling edge; unwritten data flips so stale words never match
   task automatic cyc(input logic [4:0] c, input logic [5:0] w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge mclk_i);
      ctl_o <= c;
      a_o <= a;
      wctl_o <= w;
      d_o <= (!w[5] || (!w[4] && !(&w[3:0]))) ? d : ~d_o;
   endtask : cyc
endmodule : pdss_ctl_model

// >>> tb/pdss_core_test.sv
// Self-checking bench for the sync SRAM core
`timescale 1ns/1ps
module pdss_core_test
   import pdss_pkg::*;
   ;
   localparam logic [ADDR_W-1:0] BASE = 20'hABCD4;
   logic mclk_i, sys_rst_i, burst_order_i, output_enable_n_i, sleep_input_i, burst_advance_n_i, global_write_n_i;
   logic pipelined_chip_select_n_i, depth_select_high_i, depth_select_low_n_i, byte_write_enable_n_i;
   logic processor_addr_strobe_n_i, controller_addr_strobe_n_i;
   logic [ADDR_W-1:0]       addr_i, a;
   logic [LANES-1:0]        byte_write_select_n_i, parity_data_in_i, parity_data_out_o, dq_oe_o, parity_data_oe_o;
   logic [LANES*BYTE_W-1:0] dq_in_i, dq_out_o;
   logic [4:0]              ctl;
   logic [5:0]              wctl;
   logic [DATA_W-1:0]       d, exp_w [4];
   int                      n_mismatch, n_compared;

   // Bundled model outputs fanned out to the pins
   assign {controller_addr_strobe_n_i, processor_addr_strobe_n_i, pipelined_chip_select_n_i} = ctl[4:2];
   assign {depth_select_high_i, burst_advance_n_i, depth_select_low_n_i} = {ctl[1:0], ~ctl[1]};
   assign {global_write_n_i, byte_write_enable_n_i, byte_write_select_n_i} = wctl;
   assign {parity_data_in_i, dq_in_i, addr_i} = {d, a};

   pdss_ctl_model pdss_ctl_model_i (.mclk_i(mclk_i), .ctl_o(ctl), .wctl_o(wctl), .a_o(a), .d_o(d));
   pdss_core pdss_core_i (.*);

   // 200 MHz clock
   initial
   begin
      mclk_i = 1'h0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask : chk

   task automatic op(input logic [4:0] c, input logic [5:0] w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd);
      pdss_ctl_model_i.cyc(c, w, ad, dd);
   endtask : op

   task automatic oe_is(input logic [3:0] e);
      chk("drive enable", {32'h0, e}, {32'h0, dq_oe_o});
   endtask : oe_is

   // Load, three continue cycles, deselect, then the deselect tail
   task automatic rd(input logic [4:0] c, input logic [5:0] w, input logic [ADDR_W-1:0] ad, input logic ord,
                     input logic [2:0] burst_advance);
      logic [1:0] e [4];
      logic [1:0] k;
      burst_order_i = ord;
      e[0] = ad[1:0];
      k = 2'h0;
      for (int i = 1; i < 4; i++)
      begin
         k = k + 2'(!burst_advance[i-1]);
         e[i] = ord ? (ad[1:0] ^ k) : (ad[1:0] + k);
      end
      op(c, w, ad, 36'h0);
      for (int i = 1; i < 9; i++)
      begin
         op(i < 4 ? {4'hD, burst_advance[(i-1)%3]} : (i == 4 ? 5'h09 : 5'h1B), 6'h3F, 20'h0, 36'h0);
         if (i > 2 && i < 7)
            chk("read word", exp_w[e[i-3]], {parity_data_out_o, dq_out_o});
         oe_is((i > 2 && i < 8) ? 4'hF : 4'h0);
      end
   endtask : rd

   task automatic t_fill;
      for (int k = 0; k < 4; k++)
      begin
         exp_w[k] = {4'(k + 5), 32'(32'h11111111 * (k + 1))};
         op(5'h0B, 6'h1F, BASE + 20'(k), exp_w[k]);
      end
      rd(5'h0B, 6'h3F, BASE + 20'h2, 1'h0, 3'h0);
      rd(5'h0B, 6'h3F, BASE + 20'h1, 1'h1, 3'h0);
      $display("test fill and both burst orders done");
   endtask : t_fill

   task automatic t_byte;
      op(5'h0B, 6'h2A, BASE, 36'hF_FFFFFFFF);
      op(5'h0B, 6'h30, BASE + 20'h1, 36'hF_FFFFFFFF);
      exp_w[0] = exp_w[0] | 36'h5_00FF00FF;
      // Unqualified selects turn that load into a read; its drive tail must end before the burst
      op(5'h09, 6'h3F, 20'h0, 36'h0);
      repeat (2) op(5'h1B, 6'h3F, 20'h0, 36'h0);
      chk("read word", exp_w[1], {parity_data_out_o, dq_out_o});
      rd(5'h0B, 6'h3F, BASE, 1'h0, 3'h0);
      $display("test byte writes done");
   endtask : t_byte

   // Ignored strobe, then a processor load carrying write controls
   task automatic t_proc;
      op(5'h17, 6'h00, BASE + 20'h1, 36'h0);
      rd(5'h13, 6'h00, BASE + 20'h3, 1'h0, 3'h5);
      $display("test processor strobe done");
   endtask : t_proc

   // Read stretched by continue cycles; async gates change only on falling edges
   task automatic t_oe;
      op(5'h0B, 6'h3F, BASE, 36'h0);
      repeat (3) op(5'h1B, 6'h3F, BASE, 36'h0);
      #1;
      oe_is(4'hF);
      op(5'h09, 6'h3F, 20'h0, 36'h0);
      sleep_input_i = 1'h1;
      #1;
      oe_is(4'h0);
      op(5'h1B, 6'h3F, 20'h0, 36'h0);
      sleep_input_i = 1'h0;
      output_enable_n_i = 1'h1;
      #1;
      oe_is(4'h0);
      op(5'h1B, 6'h3F, 20'h0, 36'h0);
      output_enable_n_i = 1'h0;
      sleep_input_i = 1'h1;
      #1;
      oe_is(4'h0);
      op(5'h1B, 6'h3F, 20'h0, 36'h0);
      sleep_input_i = 1'h0;
      #1;
      oe_is(4'hF);
      op(5'h1B, 6'h3F, 20'h0, 36'h0);
      oe_is(4'h0);
      chk("read word", exp_w[0], {parity_data_out_o, dq_out_o});
      $display("test output gating done");
   endtask : t_oe

   task automatic wrap_up;
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // Reset for three cycles, then the scenarios
   initial
   begin
      {sys_rst_i, burst_order_i, output_enable_n_i, sleep_input_i} = 4'h8;
      n_mismatch = 0;
      n_compared = 0;
      repeat (3) @(negedge mclk_i);
      sys_rst_i = 1'h0;
      t_fill;
      t_byte;
      t_proc;
      t_oe;
      wrap_up;
   end
endmodule : pdss_core_test
